// file: src/i2cs_pkg.sv
// constants of the two-wire slave: register map, field positions, reset values, timing
package i2cs_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] I2CS_OFS_STATUS  = 8'h00;
    localparam logic [7:0] I2CS_OFS_OWNADDR = 8'h04;
    localparam logic [7:0] I2CS_OFS_DATA    = 8'h08;
    localparam logic [7:0] I2CS_OFS_IRQ     = 8'h0c;

    // slave_status_control field positions
    localparam int I2CS_BIT_ACK_GEN_ENABLE   = 7;
    localparam int I2CS_BIT_EN     = 6;
    localparam int I2CS_BIT_IRQEN  = 5;
    localparam int I2CS_BIT_GCALL  = 4;
    localparam int I2CS_BIT_DIR    = 3;
    localparam int I2CS_BIT_BUSY   = 2;
    localparam int I2CS_BIT_MATCH  = 1;
    localparam int I2CS_BIT_LACK   = 0;

    // interrupt control register field positions
    localparam int I2CS_BIT_FLAG   = 0;
    localparam int I2CS_BIT_SYSEN  = 1;

    // reset values
    localparam logic [7:0] I2CS_RST_STATUS = 8'h00;
    localparam logic [6:0] I2CS_RST_OWN    = 7'h00;
    localparam logic [7:0] I2CS_RST_DATA   = 8'h00;

    // general call address
    localparam logic [6:0] I2CS_GCALL_ADDR = 7'h00;

    // bit counter value after a full byte
    localparam logic [3:0] I2CS_BYTE_BITS  = 4'h8;

    // timing: system clock and standard and fastest supported bus bit times
    localparam int I2CS_CLK_NS       = 50;
    localparam int I2CS_STD_BIT_NS   = 10000;
    localparam int I2CS_FAST_BIT_NS  = 2500;
    localparam int I2CS_FAST_BIT_CYC = I2CS_FAST_BIT_NS / I2CS_CLK_NS;
    localparam int I2CS_STD_BIT_CYC  = I2CS_STD_BIT_NS / I2CS_CLK_NS;

    typedef enum logic [7:0] {
        I2CS_ST_IDLE = 8'h01,
        I2CS_ST_ADDR = 8'h02,
        I2CS_ST_ACK  = 8'h04,
        I2CS_ST_RX   = 8'h08,
        I2CS_ST_TX   = 8'h10,
        I2CS_ST_RACK = 8'h20,
        I2CS_ST_WAIT = 8'h40,
        I2CS_ST_IGN  = 8'h80
    } i2cs_state_t;

endpackage : i2cs_pkg

// file: src/i2cs_sync.sv
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
module i2cs_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic meta;
        logic stable;
    } i2cs_sync_t;

    i2cs_sync_t r;
    i2cs_sync_t next_r;

    always_comb begin
        next_r.meta   = d;
        next_r.stable = r.meta;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{meta: RST_VAL, stable: RST_VAL};
        end else begin
            r <= next_r;
        end
    end

    assign q = r.stable;
endmodule : i2cs_sync

// file: src/i2cs_slave.sv
// two-wire slave interface with ahb-lite register port
// Functional notes
// - general call flag set when received address is all zeros
// - direction status loaded from read/write bit: 0 receive, 1 transmit
// - bus busy set on start, cleared on stop
// - address match set on own address, cleared on start or stop
// - last ninth bit recorded: 0 acknowledged, 1 not acknowledged
// - interrupt requested only when block and system enables are both set
// - status register readable at any time, enabled or not
// - start is data falling, stop is data rising, clock high
// - start before stop is repeated start; busy stays set
// - first byte after start is 7-bit address plus direction bit
// - matching address byte acknowledged by pulling data low in ninth clock
// - bytes shifted most significant bit first both ways
// - direction 0 master to slave, 1 slave to master
// - each received write data byte acknowledged
// - data changes only while clock low; bit ends at clock fall
// - ones by releasing open drain, zeros by driving low
// - byte done flag raised after every data byte received or sent and every acknowledged address byte
// - read request switches to transmit, write request to receive
// - received byte readable in data register; written byte sent next
// - clock held low after each flagged byte until flag cleared
// - works at 100 kbit/s and 400 kbit/s bus rates
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module i2cs_slave (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             irq
);
    typedef struct packed {
        i2cs_pkg::i2cs_state_t state;
        logic [3:0]            cnt;
        logic [7:0]            sh;
        logic [7:0]            data;
        logic [6:0]            own;
        logic                  ack_gen_enable;
        logic                  en;
        logic                  irqen;
        logic                  gcall;
        logic                  dir;
        logic                  busy;
        logic                  match;
        logic                  lack;
        logic                  flag;
        logic                  sysen;
        logic                  sda_drv;
        logic                  scl_drv;
        logic                  scl_q;
        logic                  sda_q;
        logic                  bus_act;
        logic                  bus_wr;
        logic [7:0]            bus_addr;
        logic [31:0]           rdata;
    } i2cs_regs_t;

    i2cs_regs_t r;
    i2cs_regs_t next_r;

    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       byte_end;
    logic       addr_hit;
    logic [7:0] status_byte;

    // pins are asynchronous to clk_sys; 100 ns of latency is small against a 2.5 us bit
    i2cs_sync #(.RST_VAL(1'b1)) u_sync_scl (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       (scl_in),
        .q       (scl_s)
    );

    i2cs_sync #(.RST_VAL(1'b1)) u_sync_sda (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       (sda_in),
        .q       (sda_s)
    );

    assign scl_rise  = scl_s && !r.scl_q;
    assign scl_fall  = !scl_s && r.scl_q;
    assign start_det = scl_s && r.scl_q && r.sda_q && !sda_s;
    assign stop_det  = scl_s && r.scl_q && !r.sda_q && sda_s;
    assign byte_end  = scl_fall && (r.cnt == i2cs_pkg::I2CS_BYTE_BITS);
    assign addr_hit  = (r.sh[7:1] == r.own) || (r.sh[7:1] == i2cs_pkg::I2CS_GCALL_ADDR);

    assign status_byte = {r.ack_gen_enable, r.en, r.irqen, r.gcall, r.dir, r.busy, r.match, r.lack};

    always_comb begin
        next_r       = r;
        next_r.scl_q = scl_s;
        next_r.sda_q = sda_s;

        // data phase of a write: registers take hwdata
        if (r.bus_act && r.bus_wr) begin
            case (r.bus_addr)
                i2cs_pkg::I2CS_OFS_STATUS: begin
                    next_r.ack_gen_enable  = hwdata[i2cs_pkg::I2CS_BIT_ACK_GEN_ENABLE];
                    next_r.en    = hwdata[i2cs_pkg::I2CS_BIT_EN];
                    next_r.irqen = hwdata[i2cs_pkg::I2CS_BIT_IRQEN];
                    next_r.dir   = hwdata[i2cs_pkg::I2CS_BIT_DIR];
                end
                i2cs_pkg::I2CS_OFS_OWNADDR: begin
                    next_r.own = hwdata[6:0];
                end
                i2cs_pkg::I2CS_OFS_DATA: begin
                    next_r.data = hwdata[7:0];
                end
                i2cs_pkg::I2CS_OFS_IRQ: begin
                    next_r.sysen = hwdata[i2cs_pkg::I2CS_BIT_SYSEN];
                    if (hwdata[i2cs_pkg::I2CS_BIT_FLAG]) begin
                        next_r.flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // address phase: read data is captured here, one cycle ahead of its data phase
        next_r.bus_act = hsel && hready && htrans[1];
        if (hsel && hready && htrans[1]) begin
            next_r.bus_wr   = hwrite;
            next_r.bus_addr = haddr[7:0];
            case (haddr[7:0])
                i2cs_pkg::I2CS_OFS_STATUS:  next_r.rdata = {24'h000000, status_byte};
                i2cs_pkg::I2CS_OFS_OWNADDR: next_r.rdata = {25'h0, r.own};
                i2cs_pkg::I2CS_OFS_DATA:    next_r.rdata = {24'h000000, r.data};
                i2cs_pkg::I2CS_OFS_IRQ:     next_r.rdata = {30'h0, r.sysen, r.flag};
                default:                    next_r.rdata = 32'h00000000;
            endcase
        end

        // byte engine; flag sets below override a clear in the same cycle
        case (r.state)
            i2cs_pkg::I2CS_ST_ADDR, i2cs_pkg::I2CS_ST_RX: begin
                if (scl_rise) begin
                    next_r.sh  = {r.sh[6:0], sda_s};
                    next_r.cnt = r.cnt + 4'h1;
                end else if (byte_end && r.state == i2cs_pkg::I2CS_ST_ADDR) begin
                    next_r.gcall = (r.sh[7:1] == i2cs_pkg::I2CS_GCALL_ADDR);
                    next_r.match = (r.sh[7:1] == r.own);
                    if (addr_hit && r.ack_gen_enable) begin
                        next_r.dir     = r.sh[0];
                        next_r.sda_drv = 1'b1;
                        next_r.state   = i2cs_pkg::I2CS_ST_ACK;
                    end else begin
                        next_r.state = i2cs_pkg::I2CS_ST_IGN;
                    end
                end else if (byte_end) begin
                    next_r.data    = r.sh;
                    next_r.sda_drv = r.ack_gen_enable;
                    next_r.state   = i2cs_pkg::I2CS_ST_ACK;
                end
            end
            i2cs_pkg::I2CS_ST_ACK, i2cs_pkg::I2CS_ST_RACK: begin
                if (scl_rise) begin
                    next_r.lack = sda_s;
                end else if (scl_fall) begin
                    next_r.sda_drv = 1'b0;
                    next_r.flag    = 1'b1;
                    next_r.scl_drv = 1'b1;
                    next_r.state   = i2cs_pkg::I2CS_ST_WAIT;
                end
            end
            i2cs_pkg::I2CS_ST_WAIT: begin
                // clock is stretched here, so the first transmit bit sets up while scl is low
                if (!r.flag) begin
                    next_r.scl_drv = 1'b0;
                    next_r.cnt     = 4'h0;
                    if (r.lack) begin
                        next_r.state = i2cs_pkg::I2CS_ST_IGN;
                    end else if (r.dir) begin
                        next_r.sh      = r.data;
                        next_r.sda_drv = !r.data[7];
                        next_r.state   = i2cs_pkg::I2CS_ST_TX;
                    end else begin
                        next_r.state = i2cs_pkg::I2CS_ST_RX;
                    end
                end
            end
            i2cs_pkg::I2CS_ST_TX: begin
                if (scl_rise) begin
                    next_r.cnt = r.cnt + 4'h1;
                end else if (byte_end) begin
                    next_r.sda_drv = 1'b0;
                    next_r.state   = i2cs_pkg::I2CS_ST_RACK;
                end else if (scl_fall) begin
                    next_r.sh      = {r.sh[6:0], 1'b0};
                    next_r.sda_drv = !r.sh[6];
                end
            end
            i2cs_pkg::I2CS_ST_IDLE, i2cs_pkg::I2CS_ST_IGN: begin
            end
            default: begin
                next_r.state = i2cs_pkg::I2CS_ST_IDLE;
            end
        endcase

        // bus conditions take priority over the byte engine
        if (start_det) begin
            next_r.busy    = 1'b1;
            next_r.match   = 1'b0;
            next_r.gcall   = 1'b0;
            next_r.cnt     = 4'h0;
            next_r.sda_drv = 1'b0;
            next_r.scl_drv = 1'b0;
            next_r.state   = i2cs_pkg::I2CS_ST_ADDR;
        end else if (stop_det) begin
            next_r.busy    = 1'b0;
            next_r.match   = 1'b0;
            next_r.sda_drv = 1'b0;
            next_r.scl_drv = 1'b0;
            next_r.state   = i2cs_pkg::I2CS_ST_IDLE;
        end

        // disabled module leaves the lines alone but still tracks busy
        if (!r.en) begin
            next_r.sda_drv = 1'b0;
            next_r.scl_drv = 1'b0;
            next_r.state   = i2cs_pkg::I2CS_ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r          <= '0;
            r.state    <= i2cs_pkg::I2CS_ST_IDLE;
            r.data     <= i2cs_pkg::I2CS_RST_DATA;
            r.own      <= i2cs_pkg::I2CS_RST_OWN;
            r.ack_gen_enable     <= i2cs_pkg::I2CS_RST_STATUS[i2cs_pkg::I2CS_BIT_ACK_GEN_ENABLE];
            r.en       <= i2cs_pkg::I2CS_RST_STATUS[i2cs_pkg::I2CS_BIT_EN];
            r.irqen    <= i2cs_pkg::I2CS_RST_STATUS[i2cs_pkg::I2CS_BIT_IRQEN];
            r.scl_q    <= 1'b1;
            r.sda_q    <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign hrdata    = r.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign scl_out   = 1'b0;
    assign sda_out   = 1'b0;
    assign scl_oe    = r.scl_drv;
    assign sda_oe    = r.sda_drv;
    assign irq       = r.flag && r.irqen && r.sysen;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    gcall_flag_a: assert property (
        (byte_end && r.state == i2cs_pkg::I2CS_ST_ADDR && r.sh[7:1] == 7'h00 && !start_det
         && !stop_det && r.en) |=> r.gcall)
        else $error("general call flag not set");

    dir_load_a: assert property (
        (byte_end && r.state == i2cs_pkg::I2CS_ST_ADDR && addr_hit && r.ack_gen_enable && r.en
         && !start_det && !stop_det) |=> (r.dir == $past(r.sh[0]) && sda_oe))
        else $error("direction or address ack wrong");

    busy_track_a: assert property (
        start_det |=> r.busy ##0 (r.busy || $past(stop_det)))
        else $error("busy not set by start");

    busy_stop_a: assert property (
        (stop_det && !start_det) |=> !r.busy && !r.match)
        else $error("stop did not clear busy and match");

    match_clear_a: assert property (
        start_det |=> !r.match ##1 (r.match == $past(r.match) || $past(byte_end)))
        else $error("match not cleared on start");

    irq_gate_a: assert property (
        (r.flag && !(r.irqen && r.sysen)) |-> !irq)
        else $error("interrupt without both enables");

    flag_after_byte_a: assert property (
        (scl_fall && (r.state == i2cs_pkg::I2CS_ST_ACK || r.state == i2cs_pkg::I2CS_ST_RACK)
         && r.en && !start_det && !stop_det) |=> r.flag && scl_oe && !sda_oe)
        else $error("byte end did not flag and stretch");

    stretch_hold_a: assert property (
        (r.state == i2cs_pkg::I2CS_ST_WAIT && r.flag) |-> scl_oe)
        else $error("clock released while flag set");

    release_a: assert property (
        (r.state == i2cs_pkg::I2CS_ST_WAIT && !r.flag && r.en && !start_det && !stop_det)
        |=> !scl_oe)
        else $error("clock not released after flag clear");

    nomatch_a: assert property (
        (byte_end && r.state == i2cs_pkg::I2CS_ST_ADDR && !addr_hit && r.en
         && !start_det && !stop_det) |=> (r.state == i2cs_pkg::I2CS_ST_IGN && !sda_oe)
        ##1 !sda_oe)
        else $error("unmatched address acknowledged");

    tx_first_bit_a: assert property (
        (r.state == i2cs_pkg::I2CS_ST_WAIT && !r.flag && r.dir && !r.lack && r.en
         && !start_det && !stop_det) |=> (sda_oe == !$past(r.data[7])))
        else $error("first transmit bit not msb of data");

    sda_stable_a: assert property (
        (scl_s && r.scl_q) |=> $stable(sda_oe) || $past(start_det || stop_det || !r.en))
        else $error("data changed while clock high");

    lack_capture_a: assert property (
        (scl_rise && (r.state == i2cs_pkg::I2CS_ST_ACK || r.state == i2cs_pkg::I2CS_ST_RACK)
         && r.en && !start_det && !stop_det) |=> (r.lack == $past(sda_s)))
        else $error("ninth bit not recorded");

    rx_byte_ack_a: assert property (
        (byte_end && r.state == i2cs_pkg::I2CS_ST_RX && r.en && !start_det && !stop_det)
        |=> (r.data == $past(r.sh) && sda_oe == $past(r.ack_gen_enable)))
        else $error("received byte not stored or not acknowledged");

    tx_shift_a: assert property (
        (scl_fall && !byte_end && r.state == i2cs_pkg::I2CS_ST_TX && r.en
         && !start_det && !stop_det) |=> (sda_oe == !$past(r.sh[6])))
        else $error("transmit bit out of order");

endmodule : i2cs_slave

// file: dv/i2cs_master_model.sv
// behavioural two-wire bus master that drives the slave's pins
`timescale 1ns/1ps
module i2cs_master_model (
    input  wire logic clk_sys,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // waits on the line, not a fixed time, so a stretching slave is honoured
    task automatic rise();
        scl_low <= 1'b0;
        do @(posedge clk_sys); while (scl !== 1'b1);
        cyc(3);
    endtask : rise

    task automatic bit_out(input logic b);
        cyc(2);
        sda_low <= !b;
        cyc(2);
        rise();
        scl_low <= 1'b1;
    endtask : bit_out

    task automatic bit_in(output logic b);
        cyc(2);
        sda_low <= 1'b0;
        cyc(2);
        rise();
        b = sda;
        scl_low <= 1'b1;
    endtask : bit_in

    task automatic start();
        sda_low <= 1'b1;
        cyc(4);
        scl_low <= 1'b1;
    endtask : start

    task automatic rstart();
        cyc(2);
        sda_low <= 1'b0;
        cyc(2);
        rise();
        start();
    endtask : rstart

    task automatic stop();
        cyc(2);
        sda_low <= 1'b1;
        cyc(2);
        rise();
        sda_low <= 1'b0;
        cyc(4);
    endtask : stop

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(ack);
    endtask : wr_byte

    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_in(b);
            d[i] = b;
        end
        bit_out(ack);
    endtask : rd_byte
endmodule : i2cs_master_model

// file: dv/i2c_slave_interface_tb.sv
// self-checking bench for the two-wire slave
`timescale 1ns/1ps
module i2c_slave_interface_tb;
    logic        clk_sys;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        scl_out;
    logic        sda_out;
    logic        scl_oe;
    logic        sda_oe;
    logic        irq;
    logic        scl;
    logic        sda;
    logic        m_scl_low;
    logic        m_sda_low;
    int          miscompares;
    int          total_checks;
    int          irq_count;
    logic [6:0]  own;
    logic [7:0]  d;
    logic [7:0]  t;
    logic [7:0]  rx;
    logic [31:0] r;
    logic        ack;

    assign scl = !m_scl_low && (!scl_oe || scl_out);
    assign sda = !m_sda_low && (!sda_oe || sda_out);

    i2cs_slave DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

    i2cs_master_model m (.clk_sys(clk_sys), .scl(scl), .sda(sda), .scl_low(m_scl_low),
        .sda_low(m_sda_low));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] st(input logic gc, input logic dir, input logic busy,
                                       input logic hit, input logic lack);
        return {24'h0, 3'b111, gc, dir, busy, hit, lack};
    endfunction : st

    // one single-word transfer; entered just after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("bus response", hresp, 0);
        hsel <= 1'b0;
        @(posedge clk_sys);
    endtask : ahb

    // software side of one byte interrupt
    task automatic serve(input logic [31:0] exp_st, input logic gate, input logic wr_tx,
                         input logic [7:0] tx, output logic [7:0] rx_b);
        int          n;
        logic [31:0] v;
        n = 0;
        v = 0;
        irq_count++;
        while (v[0] !== 1'b1 && n < 60) begin
            ahb(1'b0, 8'h0c, 32'h0, v);
            n++;
        end
        chk("byte done flag", v[0], 1);
        chk("clock held", scl_oe, 1);
        chk("open drain level", {scl_out, sda_out}, 0);
        chk("irq raised", irq, 1);
        if (gate) begin
            ahb(1'b1, 8'h0c, 32'h0, v);
            @(posedge clk_sys);
            chk("irq system gate", irq, 0);
            ahb(1'b1, 8'h0c, 32'h2, v);
            ahb(1'b1, 8'h00, 32'hc0, v);
            @(posedge clk_sys);
            chk("irq block gate", irq, 0);
            ahb(1'b1, 8'h00, 32'he0, v);
        end
        ahb(1'b0, 8'h00, 32'h0, v);
        chk("status", v, exp_st);
        ahb(1'b0, 8'h08, 32'h0, v);
        rx_b = v[7:0];
        if (wr_tx) ahb(1'b1, 8'h08, {24'h0, tx}, v);
        ahb(1'b1, 8'h0c, 32'h3, v);
        repeat (2) @(posedge clk_sys);
        chk("clock released", scl_oe, 0);
    endtask : serve

    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        miscompares = 0;
        total_checks = 0;
        irq_count = 0;
        void'($urandom(57473));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        ahb(1'b1, 8'h10, 32'hffffffff, r);
        for (int a = 0; a <= 16; a += 4) begin
            ahb(1'b0, a[7:0], 32'h0, r);
            chk("reset value", r, 0);
        end
        own = 7'h08 + 7'($urandom % 112);
        ahb(1'b1, 8'h04, {25'h0, own}, r);
        ahb(1'b1, 8'h0c, 32'h2, r);
        ahb(1'b1, 8'h00, 32'he0, r);
        ahb(1'b0, 8'h00, 32'h0, r);
        chk("status enabled", r, st(0, 0, 0, 0, 0));
        m.start();
        ahb(1'b0, 8'h00, 32'h0, r);
        chk("busy on start", r, st(0, 0, 1, 0, 0));
        m.wr_byte({own, 1'b0}, ack);
        chk("address ack", ack, 0);
        serve(st(0, 0, 1, 1, 0), 1'b1, 1'b0, 8'h00, rx);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            m.wr_byte(d, ack);
            chk("data ack", ack, 0);
            serve(st(0, 0, 1, 1, 0), 1'b0, 1'b0, 8'h00, rx);
            chk("received byte", rx, d);
        end
        chk("bytes in message", irq_count, 4);
        irq_count = 0;
        m.rstart();
        ahb(1'b0, 8'h00, 32'h0, r);
        chk("repeated start", r, st(0, 0, 1, 0, 0));
        m.wr_byte({own, 1'b1}, ack);
        chk("read address ack", ack, 0);
        t = 8'($urandom);
        serve(st(0, 1, 1, 1, 0), 1'b0, 1'b1, t, rx);
        for (int i = 0; i < 2; i++) begin
            m.rd_byte(i[0], d);
            chk("sent byte", d, t);
            t = 8'($urandom);
            serve(st(0, 1, 1, 1, i[0]), 1'b0, 1'b1, t, rx);
        end
        chk("bytes in message", irq_count, 3);
        m.stop();
        ahb(1'b0, 8'h00, 32'h0, r);
        chk("idle after stop", r[2:1], 0);
        m.start();
        m.wr_byte({own + 7'h01, 1'b0}, ack);
        chk("foreign address ack", ack, 1);
        ahb(1'b0, 8'h0c, 32'h0, r);
        chk("no flag for foreign", r[0], 0);
        m.stop();
        m.start();
        m.wr_byte(8'h00, ack);
        repeat (4) @(posedge clk_sys);
        ahb(1'b0, 8'h00, 32'h0, r);
        chk("general call flag", r[4], 1);
        ahb(1'b1, 8'h0c, 32'h3, r);
        m.stop();
        ahb(1'b1, 8'h00, 32'h0, r);
        m.start();
        m.wr_byte({own, 1'b0}, ack);
        chk("disabled ack", ack, 1);
        ahb(1'b0, 8'h00, 32'h0, r);
        chk("status disabled", r, 32'h04);
        m.stop();
        end_of_test();
    end
endmodule : i2c_slave_interface_tb
